/* File: bench/sjm_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module sjm_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic btn_fwd,
  input wire logic btn_rev,
  input wire logic nv_valid,
  input wire logic step,
  input wire logic dir,
  input wire logic moving
);
  import sjm_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic known_q;
  logic [31:0] shadow_q;
  assign wr = psel && penable && pwrite;
  // shadow of the jog step word; dropped at reset since a reload may replace it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      known_q <= 1'b0;
      shadow_q <= 32'h0;
    end else if (wr && paddr == SJM_REG_JOG_STEP) begin
      known_q <= 1'b1;
      shadow_q <= pwdata;
    end
  end
  AST_PREADY_HIGH: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  AST_NO_SLVERR: assert property (psel && penable |-> !pslverr)
    else $error("unexpected slave error");
  AST_UNMAPPED_ZERO: assert property (psel && !penable && !pwrite && paddr == 8'h30 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STEP_READBACK: assert property (known_q && psel && !penable && !pwrite
    && paddr == SJM_REG_JOG_STEP |=> prdata == shadow_q)
    else $error("jog step readback differs");
  AST_STEP_IN_MOTION: assert property (step |-> moving || $past(moving))
    else $error("step pulse while idle");
  AST_MOVE_STARTS: assert property (wr && paddr == SJM_REG_CMD && pwdata[SJM_CMD_MOVE_BIT]
    && !moving |-> ##[1:2] moving)
    else $error("move did not start");
  AST_FWD_BUTTON: assert property ($rose(btn_fwd) && !btn_rev && !moving |-> ##[1:6] (moving && dir))
    else $error("forward button jog did not start");
  AST_REV_BUTTON: assert property ($rose(btn_rev) && !btn_fwd && !moving |-> ##[1:6] (moving && !dir))
    else $error("reverse button jog did not start");
endmodule : sjm_asserts
bind sjm_top sjm_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .btn_fwd(btn_fwd), .btn_rev(btn_rev), .nv_valid(nv_valid), .step(step),
  .dir(dir), .moving(moving));
`default_nettype wire

/* File: bench/sjm_stage_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sjm_stage_model (
  input wire logic pclk,
  input wire logic step,
  input wire logic dir,
  input wire logic clr,
  output logic signed [31:0] pos,
  output logic signed [31:0] min_pos,
  output logic last_dir
);
  // the stage has no reset: it stays wherever the motor left it
  initial begin
    pos = 32'sh0;
    min_pos = 32'sh0;
    last_dir = 1'b1;
  end
  // one step per pulse; lowest point kept to see any overshoot
  always @(posedge pclk) begin
    if (step) begin
      pos <= dir ? pos + 32'sh1 : pos - 32'sh1;
      last_dir <= dir;
    end
    if (clr) min_pos <= pos;
    else if (step && !dir && pos - 32'sh1 < min_pos) min_pos <= pos - 32'sh1;
  end
endmodule : sjm_stage_model
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sjm_pkg::*;
  localparam logic [31:0] RST_TAB [7] = '{SJM_RST_CTRL, SJM_RST_JOG_STEP, SJM_RST_JOG_VEL,
    SJM_RST_JOG_ACC, SJM_RST_MOV_VEL, SJM_RST_MOV_ACC, SJM_RST_BACKLASH};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, step, dir, moving, mlast;
  logic btn_fwd = 1'b0, btn_rev = 1'b0, nv_valid = 1'b0, clr = 1'b0;
  logic signed [31:0] mpos, mmin, p0, dlt;
  int error_cnt = 0, checks_done = 0;

  always #5 pclk = ~pclk;

  sjm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .btn_fwd(btn_fwd), .btn_rev(btn_rev), .nv_valid(nv_valid), .step(step), .dir(dir),
    .moving(moving));
  sjm_stage_model stage (.pclk(pclk), .step(step), .dir(dir), .clr(clr), .pos(mpos),
    .min_pos(mmin), .last_dir(mlast));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  // bounded wait for motion to end
  task automatic idle_within(input int n);
    int used;
    used = 0;
    repeat (3) @(posedge pclk);
    while (moving !== 1'b0 && used < n) begin
      @(posedge pclk);
      used++;
    end
  endtask : idle_within

  // a decoy target written mid-move must not redirect the running move
  task automatic move_to(input logic [31:0] t, input logic [31:0] lo, input logic ldir);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, SJM_REG_TARGET, t);
    apb(1'b1, SJM_REG_CMD, 32'h1);
    apb(1'b1, SJM_REG_TARGET, 32'h7);
    idle_within(8000);
    chk("move done", 32'h0, {31'h0, moving});
    chk("stage position", t, mpos);
    rdchk("position word", SJM_REG_POS, t);
    chk("lowest point", lo, mmin);
    chk("final approach", {31'h0, ldir}, {31'h0, mlast});
  endtask : move_to

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    for (int i = 0; i < 7; i++) rdchk("reset value", 8'(4 * i), RST_TAB[i]);
    apb(1'b1, 8'h30, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h30, 32'h0);
    $display("register test done");
    // moves: plain, short, reverse with and without overshoot, s-curve
    apb(1'b1, SJM_REG_MOV_VEL, 32'h0000_8000);
    apb(1'b1, SJM_REG_MOV_ACC, 32'h0000_0100);
    move_to(32'd200, 32'd0, 1'b1);
    move_to(32'd210, 32'd200, 1'b1);
    move_to(32'd50, 32'd30, 1'b1);
    apb(1'b1, SJM_REG_BACKLASH, 32'h0);
    move_to(32'd20, 32'd20, 1'b0);
    apb(1'b1, SJM_REG_CTRL, 32'h0000_1204);
    move_to(32'd120, 32'd20, 1'b1);
    $display("move test done");
    // single and repeated step jogs from the panel buttons
    apb(1'b1, SJM_REG_CTRL, 32'h0000_0100);
    apb(1'b1, SJM_REG_JOG_STEP, 32'h5);
    apb(1'b1, SJM_REG_JOG_VEL, 32'h0000_6000);
    apb(1'b1, SJM_REG_JOG_ACC, 32'h0000_0100);
    p0 = mpos;
    btn_fwd <= 1'b1;
    repeat (3) @(posedge pclk);
    btn_fwd <= 1'b0;
    idle_within(3000);
    chk("single jog", p0 + 32'sd5, mpos);
    p0 = mpos;
    btn_rev <= 1'b1;
    for (int i = 0; i < 5000 && p0 - mpos < 12; i++) @(posedge pclk);
    btn_rev <= 1'b0;
    idle_within(3000);
    dlt = p0 - mpos;
    chk("held jog whole steps", 32'h0, dlt % 5);
    chk("held jog distance", 32'h1, {31'h0, dlt >= 15});
    $display("step jog test done");
    // continuous jog from the host, immediate then profiled stop
    apb(1'b1, SJM_REG_CTRL, 32'h0000_0101);
    p0 = mpos;
    apb(1'b1, SJM_REG_CMD, 32'h2);
    repeat (400) @(posedge pclk);
    rdchk("jog velocity", SJM_REG_VEL, 32'h0000_6000);
    apb(1'b1, SJM_REG_CMD, 32'h0);
    idle_within(20);
    chk("immediate stop", 32'h0, {31'h0, moving});
    chk("jog went forward", 32'h1, {31'h0, mpos > p0 + 32'sd100});
    apb(1'b1, SJM_REG_CTRL, 32'h0000_0103);
    apb(1'b1, SJM_REG_CMD, 32'h4);
    repeat (300) @(posedge pclk);
    apb(1'b1, SJM_REG_CMD, 32'h0);
    idle_within(20);
    chk("ramping down", 32'h1, {31'h0, moving});
    idle_within(3000);
    chk("ramp ended", 32'h0, {31'h0, moving});
    $display("continuous jog test done");
    // saved set comes back after a reset with a valid store
    apb(1'b1, SJM_REG_JOG_STEP, 32'h21);
    apb(1'b1, SJM_REG_CMD, 32'h8);
    for (int i = 0; i < 50; i++) begin
      apb(1'b0, SJM_REG_STATUS, 32'h0);
      if (rd[4] === 1'b0) break;
    end
    presetn <= 1'b0;
    nv_valid <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (14) @(posedge pclk);
    rdchk("reloaded step", SJM_REG_JOG_STEP, 32'h21);
    rdchk("reloaded ctrl", SJM_REG_CTRL, 32'h0000_0103);
    $display("persist test done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

/* File: src/sjm_nvram.sv */
`timescale 1ns/10ps
`default_nettype none
module sjm_nvram #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  // contents are meant to survive power loss, so no reset here
  logic [31:0] mem [DEPTH];

  // registered read, write-first not needed
  always_ff @(posedge pclk) begin
    if (we) mem[addr] <= wdata;
    rdata <= mem[addr];
  end
endmodule : sjm_nvram
`default_nettype wire

/* File: src/sjm_pkg.sv */
package sjm_pkg;

  // register byte offsets
  localparam logic [7:0] SJM_REG_CTRL = 8'h00;
  localparam logic [7:0] SJM_REG_JOG_STEP = 8'h04;
  localparam logic [7:0] SJM_REG_JOG_VEL = 8'h08;
  localparam logic [7:0] SJM_REG_JOG_ACC = 8'h0C;
  localparam logic [7:0] SJM_REG_MOV_VEL = 8'h10;
  localparam logic [7:0] SJM_REG_MOV_ACC = 8'h14;
  localparam logic [7:0] SJM_REG_BACKLASH = 8'h18;
  localparam logic [7:0] SJM_REG_TARGET = 8'h1C;
  localparam logic [7:0] SJM_REG_CMD = 8'h20;
  localparam logic [7:0] SJM_REG_STATUS = 8'h24;
  localparam logic [7:0] SJM_REG_POS = 8'h28;
  localparam logic [7:0] SJM_REG_VEL = 8'h2C;

  // ctrl field positions
  localparam int SJM_CTRL_CONT_BIT = 0;
  localparam int SJM_CTRL_PROF_STOP_BIT = 1;
  localparam int SJM_CTRL_SCURVE_BIT = 2;
  localparam int SJM_CTRL_BOW_LSB = 8;
  localparam int SJM_CTRL_BOW_W = 5;

  // cmd field positions
  localparam int SJM_CMD_MOVE_BIT = 0;
  localparam int SJM_CMD_JOG_FWD_BIT = 1;
  localparam int SJM_CMD_JOG_REV_BIT = 2;
  localparam int SJM_CMD_SAVE_BIT = 3;
  localparam int SJM_CMD_STOP_BIT = 4;

  // bow index bounds
  localparam logic [4:0] SJM_BOW_MIN = 5'h01;
  localparam logic [4:0] SJM_BOW_MAX = 5'h12;

  // reset values of the profile set
  localparam logic [31:0] SJM_RST_CTRL = 32'h0000_0102;
  localparam logic [31:0] SJM_RST_JOG_STEP = 32'h0000_0064;
  localparam logic [31:0] SJM_RST_JOG_VEL = 32'h0001_0000;
  localparam logic [31:0] SJM_RST_JOG_ACC = 32'h0000_0100;
  localparam logic [31:0] SJM_RST_MOV_VEL = 32'h0004_0000;
  localparam logic [31:0] SJM_RST_MOV_ACC = 32'h0000_0400;
  localparam logic [31:0] SJM_RST_BACKLASH = 32'h0000_0014;

  // number of persisted words
  localparam int SJM_NV_WORDS = 7;

  // cycles the load waits for the store-valid flag to cross its synchroniser
  localparam logic [1:0] SJM_NV_SETTLE = 2'h3;

  typedef enum {
    SJM_ST_LOAD,
    SJM_ST_IDLE,
    SJM_ST_RUN,
    SJM_ST_SAVE
  } sjm_state_t;

  // one persisted parameter set
  typedef struct packed {
    logic [31:0] backlash;
    logic [31:0] mov_acc;
    logic [31:0] mov_vel;
    logic [31:0] jog_acc;
    logic [31:0] jog_vel;
    logic [31:0] jog_step;
    logic [31:0] ctrl;
  } sjm_params_t;

  // profile request to the generator
  typedef struct packed {
    logic start;
    logic cont;
    logic signed [31:0] target;
    logic [31:0] vel;
    logic [31:0] acc;
    logic [31:0] jerk;
    logic scurve;
  } sjm_prof_req_t;

  // step outputs toward the motor driver
  typedef struct packed {
    logic step;
    logic dir;
  } sjm_step_t;

  // jerk limit from the bow index, clamped into range
  function automatic logic [31:0] sjm_bow_to_jerk(input logic [4:0] bow);
    logic [4:0] b;
    b = bow;
    if (b < SJM_BOW_MIN) b = SJM_BOW_MIN;
    if (b > SJM_BOW_MAX) b = SJM_BOW_MAX;
    return 32'h0000_0001 << (b - 5'h01);
  endfunction : sjm_bow_to_jerk

endpackage : sjm_pkg

/* File: src/sjm_profile_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module sjm_profile_gen
  import sjm_pkg::*;
#(
  parameter int FRAC = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire sjm_pkg::sjm_prof_req_t req,
  input wire logic halt_now,
  input wire logic halt_ramp,
  output sjm_pkg::sjm_step_t step_o,
  output logic busy,
  output logic signed [31:0] pos,
  output logic [31:0] vel
);
  // velocity and position carry FRAC fraction bits
  typedef struct packed {
    logic busy;
    logic cont;
    logic stopping;
    logic scurve;
    logic dir;
    logic signed [31:0] target;
    logic signed [31:0] pos;
    logic [FRAC-1:0] frac;
    logic [31:0] vel;
    logic [31:0] acc_cur;
    logic [31:0] vmax;
    logic [31:0] amax;
    logic [31:0] jerk;
    logic step;
  } sjm_pg_t;

  sjm_pg_t s_q, s_d;
  logic [31:0] remain;
  logic [63:0] brake;
  logic [31:0] a_eff;
  logic [FRAC:0] fsum;

  // velocity follows a trapezoid; s-curve only limits how fast acc grows
  always_comb begin
    s_d = s_q;
    s_d.step = 1'b0;
    remain = s_q.dir ? 32'(s_q.target - s_q.pos) : 32'(s_q.pos - s_q.target);
    // distance needed to stop: v^2 / (2a); fractions kept until the last shift so slow ramps brake
    brake = ((64'(s_q.vel) * 64'(s_q.vel)) / (64'(s_q.amax) * 64'h2 + 64'h1)) >> FRAC;
    a_eff = s_q.scurve ? s_q.acc_cur : s_q.amax;
    fsum = '0;
    if (req.start) begin
      s_d.busy = 1'b1;
      s_d.cont = req.cont;
      s_d.stopping = 1'b0;
      s_d.target = req.target;
      s_d.dir = req.cont ? req.target[0] : (req.target >= s_q.pos); // start from rest
      s_d.vel = '0;
      s_d.acc_cur = '0;
      s_d.vmax = req.vel;
      s_d.amax = req.acc;
      s_d.jerk = req.jerk;
      s_d.scurve = req.scurve;
      s_d.frac = '0;
    end else if (s_q.busy) begin
      if (halt_now) begin
        s_d.busy = 1'b0;
        s_d.vel = '0;
      end else begin
        if (halt_ramp) s_d.stopping = 1'b1;
        if (s_q.scurve && s_q.acc_cur < s_q.amax) begin
          // jerk raises the acceleration but never past the set value
          s_d.acc_cur = (s_q.amax - s_q.acc_cur > s_q.jerk) ? s_q.acc_cur + s_q.jerk : s_q.amax;
        end
        // decelerate when braking distance reached, else accelerate up to vmax
        if (s_q.stopping || (!s_q.cont && 64'(remain) <= brake)) begin
          // short of the target at the ramp bottom: creep at amax, raising a slower speed up to amax
          s_d.vel = (s_q.vel > s_q.amax) ? s_q.vel - s_q.amax : s_q.amax;
          if (s_q.stopping && s_q.vel <= s_q.amax) begin
            s_d.busy = 1'b0;
            s_d.vel = '0;
          end
        end else if (s_q.vel < s_q.vmax) begin
          s_d.vel = (s_q.vmax - s_q.vel > a_eff) ? s_q.vel + a_eff : s_q.vmax;
        end
        fsum = {1'b0, s_q.frac} + {1'b0, s_q.vel[FRAC-1:0]} + (s_q.vel[FRAC+:FRAC] != '0 ? {1'b1, {FRAC{1'b0}}} : '0);
        s_d.frac = fsum[FRAC-1:0];
        if (fsum[FRAC] && (s_q.cont || remain != '0)) begin
          s_d.step = 1'b1;
          s_d.pos = s_q.dir ? s_q.pos + 32'sd1 : s_q.pos - 32'sd1;
        end
        if (!s_q.cont && remain == '0) begin
          s_d.busy = 1'b0;
          s_d.vel = '0;
        end
      end
    end
  end

  // single register for the whole generator state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign step_o.step = s_q.step;
  assign step_o.dir = s_q.dir;
  assign busy = s_q.busy;
  assign pos = s_q.pos;
  assign vel = s_q.vel;
endmodule : sjm_profile_gen
`default_nettype wire

/* File: src/sjm_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Contract
// - step jog moves exactly one step distance
// - held jog repeats steps until released
// - continuous jog ramps, runs while held
// - immediate stop halts steps at once
// - profiled stop ramps down with jog set
// - acceleration shapes both ramps; separate sets
// - short move: accelerate then decelerate only
// - reverse move overshoots by backlash, returns
// - zero backlash disables overshoot
// - saved parameters reload at power-up
// - panel and host jogs share settings
// - symmetric trapezoid from zero velocity; with s-curve on, jerk limits only the rising ramp
// - jerk equals two to bow minus one
module sjm_top
  import sjm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic btn_fwd,
  input wire logic btn_rev,
  input wire logic nv_valid,
  output logic step,
  output logic dir,
  output logic moving
);
  typedef enum {
    SJM_K_NONE,
    SJM_K_STEPJOG,
    SJM_K_CONTJOG,
    SJM_K_MOVE,
    SJM_K_BACK
  } sjm_kind_t;

  typedef struct packed {
    sjm_state_t st;
    sjm_kind_t kind;
    logic [2:0] nv_idx;
    sjm_params_t p;
    logic signed [31:0] target;
    logic signed [31:0] final_target;
    logic host_fwd;
    logic host_rev;
    logic jog_dir;
    logic [1:0] bf_s1;
    logic [1:0] bf_s2;
    logic [2:0] nv_s;
    logic [1:0] settle;
    logic [31:0] rdata;
    logic start;
    sjm_prof_req_t req;
  } sjm_top_st_t;

  sjm_top_st_t s_q, s_d;
  logic pg_busy;
  logic signed [31:0] pg_pos;
  logic [31:0] pg_vel;
  sjm_step_t pg_step;
  logic nv_we;
  logic [2:0] nv_addr;
  logic [31:0] nv_wdata;
  logic [31:0] nv_rdata;
  logic wr_en;
  logic rd_en;
  logic jog_fwd;
  logic jog_rev;
  logic jog_any;
  logic halt_now;
  logic halt_ramp;

  // pick the persisted word for an index
  function automatic logic [31:0] sjm_nv_word(input sjm_params_t p, input logic [2:0] i);
    logic [31:0] w [SJM_NV_WORDS];
    w = '{p.ctrl, p.jog_step, p.jog_vel, p.jog_acc, p.mov_vel, p.mov_acc, p.backlash};
    return (32'(i) < SJM_NV_WORDS) ? w[i] : '0;
  endfunction : sjm_nv_word

  // always ready: zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // panel buttons pass two flops; host flags already on this clock
  assign jog_fwd = s_q.bf_s2[0] || s_q.host_fwd;
  assign jog_rev = s_q.bf_s2[1] || s_q.host_rev;
  assign jog_any = jog_fwd || jog_rev;
  // release decides the stop style for continuous jogs
  assign halt_now = (s_q.kind == SJM_K_CONTJOG) && !jog_any && !s_q.p.ctrl[SJM_CTRL_PROF_STOP_BIT];
  assign halt_ramp = (s_q.kind == SJM_K_CONTJOG) && !jog_any && s_q.p.ctrl[SJM_CTRL_PROF_STOP_BIT];

  // non-volatile port: reads during load, writes during save
  assign nv_we = (s_q.st == SJM_ST_SAVE);
  assign nv_addr = s_q.nv_idx;
  assign nv_wdata = sjm_nv_word(s_q.p, s_q.nv_idx);

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.bf_s1 = {btn_rev, btn_fwd};
    s_d.bf_s2 = s_q.bf_s1;
    s_d.nv_s = {s_q.nv_s[1:0], nv_valid};
    // register writes: parameters steer the next command, except the ctrl profiled-stop bit, read live by a running continuous jog
    if (wr_en) begin
      case (paddr)
        SJM_REG_CTRL: s_d.p.ctrl = pwdata;
        SJM_REG_JOG_STEP: s_d.p.jog_step = pwdata;
        SJM_REG_JOG_VEL: s_d.p.jog_vel = pwdata;
        SJM_REG_JOG_ACC: s_d.p.jog_acc = pwdata;
        SJM_REG_MOV_VEL: s_d.p.mov_vel = pwdata;
        SJM_REG_MOV_ACC: s_d.p.mov_acc = pwdata;
        SJM_REG_BACKLASH: s_d.p.backlash = pwdata;
        SJM_REG_TARGET: s_d.target = pwdata;
        SJM_REG_CMD: begin
          s_d.host_fwd = pwdata[SJM_CMD_JOG_FWD_BIT];
          s_d.host_rev = pwdata[SJM_CMD_JOG_REV_BIT];
        end
        default: ;
      endcase
    end
    // read data registered in the setup cycle
    if (rd_en) begin
      case (paddr)
        SJM_REG_CTRL: s_d.rdata = s_q.p.ctrl;
        SJM_REG_JOG_STEP: s_d.rdata = s_q.p.jog_step;
        SJM_REG_JOG_VEL: s_d.rdata = s_q.p.jog_vel;
        SJM_REG_JOG_ACC: s_d.rdata = s_q.p.jog_acc;
        SJM_REG_MOV_VEL: s_d.rdata = s_q.p.mov_vel;
        SJM_REG_MOV_ACC: s_d.rdata = s_q.p.mov_acc;
        SJM_REG_BACKLASH: s_d.rdata = s_q.p.backlash;
        SJM_REG_TARGET: s_d.rdata = s_q.target;
        SJM_REG_STATUS: s_d.rdata = {27'h0, s_q.st == SJM_ST_SAVE, s_q.st == SJM_ST_LOAD,
                                     s_q.kind == SJM_K_BACK, pg_step.dir, pg_busy};
        SJM_REG_POS: s_d.rdata = pg_pos;
        SJM_REG_VEL: s_d.rdata = pg_vel;
        default: s_d.rdata = '0;
      endcase
    end
    case (s_q.st)
      // walk the stored set in at power-up if it holds valid data
      SJM_ST_LOAD: begin
        // the synchroniser is empty after reset; deciding early would skip a valid set
        if (s_q.settle != SJM_NV_SETTLE) begin
          s_d.settle = s_q.settle + 2'h1;
        end else if (!s_q.nv_s[2]) begin
          s_d.st = SJM_ST_IDLE;
        end else begin
          s_d.nv_idx = s_q.nv_idx + 3'h1;
          // read data lags address by one cycle
          case (s_q.nv_idx)
            3'h1: s_d.p.ctrl = nv_rdata;
            3'h2: s_d.p.jog_step = nv_rdata;
            3'h3: s_d.p.jog_vel = nv_rdata;
            3'h4: s_d.p.jog_acc = nv_rdata;
            3'h5: s_d.p.mov_vel = nv_rdata;
            3'h6: s_d.p.mov_acc = nv_rdata;
            3'h7: begin
              s_d.p.backlash = nv_rdata;
              s_d.st = SJM_ST_IDLE;
            end
            default: ;
          endcase
        end
      end
      SJM_ST_IDLE: begin
        s_d.nv_idx = '0;
        s_d.req.vel = s_q.p.mov_vel;
        s_d.req.acc = s_q.p.mov_acc;
        s_d.req.cont = 1'b0;
        s_d.req.scurve = s_q.p.ctrl[SJM_CTRL_SCURVE_BIT];
        s_d.req.jerk = sjm_bow_to_jerk(s_q.p.ctrl[SJM_CTRL_BOW_LSB+:SJM_CTRL_BOW_W]);
        if (wr_en && paddr == SJM_REG_CMD && pwdata[SJM_CMD_SAVE_BIT]) begin
          s_d.st = SJM_ST_SAVE;
        end else if (wr_en && paddr == SJM_REG_CMD && pwdata[SJM_CMD_MOVE_BIT]) begin
          s_d.st = SJM_ST_RUN;
          s_d.start = 1'b1;
          s_d.final_target = s_q.target;
          s_d.kind = SJM_K_MOVE;
          // reverse with backlash: aim past the target first
          if (s_q.target < pg_pos && s_q.p.backlash != '0) begin
            s_d.req.target = s_q.target - $signed(s_q.p.backlash);
          end else begin
            s_d.req.target = s_q.target;
          end
        end else if (jog_any) begin
          s_d.st = SJM_ST_RUN;
          s_d.start = 1'b1;
          s_d.jog_dir = jog_fwd;
          s_d.req.vel = s_q.p.jog_vel;
          s_d.req.acc = s_q.p.jog_acc;
          if (s_q.p.ctrl[SJM_CTRL_CONT_BIT]) begin
            s_d.kind = SJM_K_CONTJOG;
            s_d.req.cont = 1'b1;
            s_d.req.target = {31'h0, jog_fwd}; // bit 0 carries direction
          end else begin
            s_d.kind = SJM_K_STEPJOG;
            s_d.req.target = jog_fwd ? pg_pos + $signed(s_q.p.jog_step)
                                     : pg_pos - $signed(s_q.p.jog_step);
          end
        end
      end
      SJM_ST_RUN: begin
        if (!s_q.start && !pg_busy) begin
          if (s_q.kind == SJM_K_MOVE && s_q.req.target != s_q.final_target) begin
            s_d.kind = SJM_K_BACK;
            s_d.start = 1'b1;
            s_d.req.target = s_q.final_target;
          end else begin
            // back to idle; a still-held step jog starts the next step there
            s_d.st = SJM_ST_IDLE;
            s_d.kind = SJM_K_NONE;
          end
        end
      end
      SJM_ST_SAVE: begin
        s_d.nv_idx = s_q.nv_idx + 3'h1;
        if (32'(s_q.nv_idx) == SJM_NV_WORDS - 1) begin
          s_d.st = SJM_ST_IDLE;
        end
      end
      default: s_d.st = SJM_ST_IDLE;
    endcase
    s_d.req.start = s_d.start;
  end

  // whole top-level state in one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= SJM_ST_LOAD;
      s_q.kind <= SJM_K_NONE;
      s_q.p <= '{SJM_RST_BACKLASH, SJM_RST_MOV_ACC, SJM_RST_MOV_VEL, SJM_RST_JOG_ACC,
                 SJM_RST_JOG_VEL, SJM_RST_JOG_STEP, SJM_RST_CTRL};
    end else begin
      s_q <= s_d;
    end
  end

  sjm_nvram #(.DEPTH(8), .AW(3)) u_nv (
    .pclk(pclk),
    .we(nv_we),
    .addr(nv_addr),
    .wdata(nv_wdata),
    .rdata(nv_rdata)
  );

  sjm_profile_gen #(.FRAC(16)) u_pg (
    .pclk(pclk),
    .presetn(presetn),
    .req(s_q.req),
    .halt_now(halt_now),
    .halt_ramp(halt_ramp),
    .step_o(pg_step),
    .busy(pg_busy),
    .pos(pg_pos),
    .vel(pg_vel)
  );

  assign prdata = s_q.rdata;
  assign step = pg_step.step;
  assign dir = pg_step.dir;
  assign moving = pg_busy || (s_q.st == SJM_ST_RUN);
endmodule : sjm_top
`default_nettype wire
